// [texel_codec_regs.svh]
// bit positions, reset values and timing counts of the texel block decoder
`ifndef TEXEL_CODEC_REGS_SVH
`define TEXEL_CODEC_REGS_SVH

`define BLOCK_W             64
`define TEXEL_COUNT         16
`define PIPE_LATENCY        1
`define VALID_RESET         1'b0
`define READY_RESET         1'b0

// mode selection and differential fields
`define RED_F               63:59
`define RED_DELTA_F         58:56
`define GREEN_F             55:51
`define GREEN_DELTA_F       50:48
`define BLUE_F              47:43
`define BLUE_DELTA_F        42:40
`define FIRST_SELECTOR_F    39:37
`define SECOND_SELECTOR_F   36:34
`define OPACITY_BIT         33
`define ORIENT_BIT          32
`define INDEX_HIGH_BASE     16

// T mode fields
`define T_RED_ONE_UPPER_F   60:59
`define T_RED_ONE_LOWER_F   57:56
`define T_GREEN_ONE_F       55:52
`define T_BLUE_ONE_F        51:48
`define T_RED_TWO_F         47:44
`define T_GREEN_TWO_F       43:40
`define T_BLUE_TWO_F        39:36
`define T_DIST_UPPER_F      35:34
`define T_DIST_LOWER_BIT    32

// H mode fields
`define H_RED_ONE_F         62:59
`define H_GREEN_ONE_UPPER_F 58:56
`define H_GREEN_ONE_LOWER_B 52
`define H_BLUE_ONE_UPPER_B  51
`define H_BLUE_ONE_LOWER_F  49:47
`define H_RED_TWO_F         46:43
`define H_GREEN_TWO_F       42:39
`define H_BLUE_TWO_F        38:35
`define H_DIST_UPPER_BIT    34
`define H_DIST_LOWER_BIT    32

// planar fields
`define P_ORIGIN_RED_F      62:57
`define P_ORIGIN_GREEN_UP_B 56
`define P_ORIGIN_GREEN_LO_F 54:49
`define P_ORIGIN_BLUE_TOP_B 48
`define P_ORIGIN_BLUE_MID_F 44:43
`define P_ORIGIN_BLUE_LOW_F 41:39
`define P_HORIZ_RED_UP_F    38:34
`define P_HORIZ_RED_LO_B    32
`define P_HORIZ_GREEN_F     31:25
`define P_HORIZ_BLUE_F      24:19
`define P_VERT_RED_F        18:13
`define P_VERT_GREEN_F      12:6
`define P_VERT_BLUE_F       5:0

`endif

// [texel_codec_pkg.sv]
// types shared by the texel block decoder
package texel_codec_pkg;

	typedef enum logic [1:0] {
		MODE_DIFF,
		MODE_T,
		MODE_H,
		MODE_PLANAR
	} mode_e;

	typedef struct packed {
		logic [7:0] red;
		logic [7:0] green;
		logic [7:0] blue;
		logic [7:0] alpha;
	} texel_s;

	typedef struct packed {
		logic [3:0] red_one;
		logic [3:0] green_one;
		logic [3:0] blue_one;
		logic [3:0] red_two;
		logic [3:0] green_two;
		logic [3:0] blue_two;
		logic [2:0] dist_index;
	} pair_fields_s;

	typedef struct packed {
		logic [5:0] origin_red;
		logic [6:0] origin_green;
		logic [5:0] origin_blue;
		logic [5:0] horiz_red;
		logic [6:0] horiz_green;
		logic [5:0] horiz_blue;
		logic [5:0] vert_red;
		logic [6:0] vert_green;
		logic [5:0] vert_blue;
	} planar_fields_s;

	typedef struct packed {
		logic [63:0]     raw;
		mode_e           mode;
		logic            opacity_flag;
		texel_s [15:0]   texels;
		pair_fields_s    t_fields;
		pair_fields_s    h_fields;
		planar_fields_s  planar;
	} result_s;

endpackage

// [texel_block_decoder.sv]
// decoder for one 64-bit four-channel punch-through texel block
`timescale 1ns/1ns
`include "texel_codec_regs.svh"

module texel_block_decoder (
	// clock and reset
	input  wire logic                      core_clk_in,
	input  wire logic                      rst_in,
	// block input
	input  wire logic                      in_valid_in,
	input  wire logic [63:0]               block_in,
	output logic                           in_ready_out,
	// decoded output
	output logic                           out_valid_out,
	input  wire logic                      out_ready_in,
	output texel_codec_pkg::result_s       result_out
);
	import texel_codec_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// arithmetic helpers

	// widen a five-bit colour into eight bits
	function automatic logic [7:0] widen5(input logic [4:0] v);
		widen5 = {v, v[4:2]};
	endfunction

	// five-bit colour plus signed three-bit delta, seven bits signed
	function automatic logic signed [6:0] add_delta(input logic [4:0] c,
			input logic [2:0] d);
		add_delta = $signed({2'b00, c}) + $signed({{4{d[2]}}, d});
	endfunction

	// sum that leaves 0..31 forces a non-differential mode
	function automatic logic overflow(input logic [4:0] c,
			input logic [2:0] d);
		logic signed [6:0] s;
		s = add_delta(c, d);
		overflow = (s < 0) || (s > 7'sh1F);
	endfunction

	// large modifier magnitude per table selector
	function automatic logic [7:0] large_mod(input logic [2:0] sel);
		case (sel)
			3'h0: large_mod = 8'h08;
			3'h1: large_mod = 8'h11;
			3'h2: large_mod = 8'h1D;
			3'h3: large_mod = 8'h2A;
			3'h4: large_mod = 8'h3C;
			3'h5: large_mod = 8'h50;
			3'h6: large_mod = 8'h6A;
			default: large_mod = 8'hB7;
		endcase
	endfunction

	// small modifier magnitude per table selector
	function automatic logic [7:0] small_mod(input logic [2:0] sel);
		case (sel)
			3'h0: small_mod = 8'h02;
			3'h1: small_mod = 8'h05;
			3'h2: small_mod = 8'h09;
			3'h3: small_mod = 8'h0D;
			3'h4: small_mod = 8'h12;
			3'h5: small_mod = 8'h18;
			3'h6: small_mod = 8'h21;
			default: small_mod = 8'h2F;
		endcase
	endfunction

	// add a signed modifier to a channel and clamp to a byte
	function automatic logic [7:0] add_clamp(input logic [7:0] base,
			input logic signed [9:0] m);
		logic signed [10:0] s;
		s = $signed({3'b000, base}) + $signed({m[9], m});
		if (s < 0) begin
			add_clamp = 8'h00;
		end else if (s > 11'sh0FF) begin
			add_clamp = 8'hFF;
		end else begin
			add_clamp = s[7:0];
		end
	endfunction

	// base channel of the half a texel falls in, used by decode and checks
	function automatic logic [7:0] half_base(input logic second,
			input logic [4:0] c, input logic [2:0] d);
		logic signed [6:0] s;
		s = add_delta(c, d);
		half_base = second ? widen5(s[4:0]) : widen5(c);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// full decode of one block, purely combinational

	function automatic result_s decode(input logic [63:0] b);
		result_s          r;
		logic             second;
		logic [1:0]       idx;
		logic [2:0]       sel;
		logic signed [9:0] m;
		logic [7:0]       br;
		logic [7:0]       bg;
		logic [7:0]       bb;
		r = '0;
		r.raw = b;
		r.opacity_flag = b[`OPACITY_BIT];
		// mode priority: red, then green, then blue overflow
		if (overflow(b[`RED_F], b[`RED_DELTA_F])) begin
			r.mode = MODE_T;
		end else if (overflow(b[`GREEN_F], b[`GREEN_DELTA_F])) begin
			r.mode = MODE_H;
		end else if (overflow(b[`BLUE_F], b[`BLUE_DELTA_F])) begin
			r.mode = MODE_PLANAR;
		end else begin
			r.mode = MODE_DIFF;
		end
		// T mode: red one split over two groups
		r.t_fields.red_one   = {b[`T_RED_ONE_UPPER_F],
			b[`T_RED_ONE_LOWER_F]};
		r.t_fields.green_one = b[`T_GREEN_ONE_F];
		r.t_fields.blue_one  = b[`T_BLUE_ONE_F];
		r.t_fields.red_two   = b[`T_RED_TWO_F];
		r.t_fields.green_two = b[`T_GREEN_TWO_F];
		r.t_fields.blue_two  = b[`T_BLUE_TWO_F];
		r.t_fields.dist_index = {b[`T_DIST_UPPER_F], b[`T_DIST_LOWER_BIT]};
		// H mode: green and blue one split; low distance bit tied to zero
		r.h_fields.red_one   = b[`H_RED_ONE_F];
		r.h_fields.green_one = {b[`H_GREEN_ONE_UPPER_F],
			b[`H_GREEN_ONE_LOWER_B]};
		r.h_fields.blue_one  = {b[`H_BLUE_ONE_UPPER_B],
			b[`H_BLUE_ONE_LOWER_F]};
		r.h_fields.red_two   = b[`H_RED_TWO_F];
		r.h_fields.green_two = b[`H_GREEN_TWO_F];
		r.h_fields.blue_two  = b[`H_BLUE_TWO_F];
		r.h_fields.dist_index = {b[`H_DIST_UPPER_BIT],
			b[`H_DIST_LOWER_BIT], 1'b0};
		// planar: origin green and blue joined from scattered groups
		r.planar.origin_red   = b[`P_ORIGIN_RED_F];
		r.planar.origin_green = {b[`P_ORIGIN_GREEN_UP_B],
			b[`P_ORIGIN_GREEN_LO_F]};
		r.planar.origin_blue  = {b[`P_ORIGIN_BLUE_TOP_B],
			b[`P_ORIGIN_BLUE_MID_F], b[`P_ORIGIN_BLUE_LOW_F]};
		r.planar.horiz_red    = {b[`P_HORIZ_RED_UP_F], b[`P_HORIZ_RED_LO_B]};
		r.planar.horiz_green  = b[`P_HORIZ_GREEN_F];
		r.planar.horiz_blue   = b[`P_HORIZ_BLUE_F];
		r.planar.vert_red     = b[`P_VERT_RED_F];
		r.planar.vert_green   = b[`P_VERT_GREEN_F];
		r.planar.vert_blue    = b[`P_VERT_BLUE_F];
		// texels, column-major a..p; only differential builds colours
		for (int i = 0; i < `TEXEL_COUNT; i++) begin
			second = b[`ORIENT_BIT] ? i[1] : i[3];
			idx = {b[`INDEX_HIGH_BASE + i], b[i]};
			sel = second ? b[`SECOND_SELECTOR_F]
				: b[`FIRST_SELECTOR_F];
			case (idx)
				2'b11: m = -$signed({2'b00, large_mod(sel)});
				2'b01: m = $signed({2'b00, large_mod(sel)});
				2'b10: m = b[`OPACITY_BIT] ?
					-$signed({2'b00, small_mod(sel)}) : 10'sh000;
				default: m = b[`OPACITY_BIT] ?
					$signed({2'b00, small_mod(sel)}) : 10'sh000;
			endcase
			br = half_base(second, b[`RED_F], b[`RED_DELTA_F]);
			bg = half_base(second, b[`GREEN_F], b[`GREEN_DELTA_F]);
			bb = half_base(second, b[`BLUE_F], b[`BLUE_DELTA_F]);
			if (r.mode != MODE_DIFF) begin
				r.texels[i] = '0;
			end else if (!b[`OPACITY_BIT] && idx == 2'b10) begin
				r.texels[i] = '0;
			end else begin
				r.texels[i].red   = add_clamp(br, m);
				r.texels[i].green = add_clamp(bg, m);
				r.texels[i].blue  = add_clamp(bb, m);
				r.texels[i].alpha = 8'hFF;
			end
		end
		decode = r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// two-entry skid buffer: output stage plus one spare slot

	logic     out_valid;
	logic     skid_valid;
	logic     ready;
	result_s  out_data;
	result_s  skid_data;
	logic     next_out_valid;
	logic     next_skid_valid;
	logic     next_ready;
	result_s  next_out_data;
	result_s  next_skid_data;
	logic     accept;

	// ready is registered so a stall costs one spare slot, not a lost word
	always_comb begin
		accept = in_valid_in && ready;
		next_out_valid = out_valid;
		next_out_data = out_data;
		next_skid_valid = skid_valid;
		next_skid_data = skid_data;
		if (!out_valid || out_ready_in) begin
			if (skid_valid) begin
				next_out_valid = 1'b1;
				next_out_data = skid_data;
				next_skid_valid = 1'b0;
				if (accept) begin
					next_skid_valid = 1'b1;
					next_skid_data = decode(block_in);
				end
			end else begin
				next_out_valid = accept;
				if (accept) begin
					next_out_data = decode(block_in);
				end
			end
		end else if (accept) begin
			next_skid_valid = 1'b1;
			next_skid_data = decode(block_in);
		end
		next_ready = !next_skid_valid;
	end

	// register stage
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			out_valid <= `VALID_RESET;
			skid_valid <= `VALID_RESET;
			ready <= `READY_RESET;
			out_data <= '0;
			skid_data <= '0;
		end else begin
			out_valid <= next_out_valid;
			skid_valid <= next_skid_valid;
			ready <= next_ready;
			out_data <= next_out_data;
			skid_data <= next_skid_data;
		end
	end

	assign in_ready_out = ready;
	assign out_valid_out = out_valid;
	assign result_out = out_data;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);

	chk_latency_one: assert property (
		in_valid_in && ready && !out_valid |=>
			out_valid && out_data.raw == $past(block_in))
		else $error("accepted block did not appear one cycle later");

	chk_stall_hold: assert property (
		out_valid && !out_ready_in |=> out_valid && $stable(out_data))
		else $error("output changed while stalled");

	chk_mode_t_sel: assert property (
		out_valid && overflow(out_data.raw[`RED_F],
			out_data.raw[`RED_DELTA_F]) |-> out_data.mode == MODE_T)
		else $error("red overflow did not select T mode");

	chk_mode_diff_sel: assert property (
		out_valid && out_data.mode == MODE_DIFF |->
			!overflow(out_data.raw[`BLUE_F], out_data.raw[`BLUE_DELTA_F])
			&& !overflow(out_data.raw[`GREEN_F],
				out_data.raw[`GREEN_DELTA_F]))
		else $error("differential chosen despite overflow");

	chk_texel_d_base: assert property (
		out_valid && out_data.mode == MODE_DIFF && !out_data.raw[19]
			&& !out_data.raw[3] && !out_data.raw[`OPACITY_BIT] |->
			out_data.texels[3].red == half_base(out_data.raw[`ORIENT_BIT],
				out_data.raw[`RED_F], out_data.raw[`RED_DELTA_F]))
		else $error("texel d base colour wrong");

	chk_punch_zero: assert property (
		out_valid && out_data.mode == MODE_DIFF
			&& !out_data.raw[`OPACITY_BIT]
			&& out_data.raw[16] && !out_data.raw[0] |->
			out_data.texels[0] == '0)
		else $error("punch-through texel not zeroed");

	chk_t_fields: assert property (
		out_valid |-> out_data.t_fields.dist_index ==
			{out_data.raw[35:34], out_data.raw[32]})
		else $error("T distance index misplaced");

	chk_h_fields: assert property (
		out_valid |-> out_data.h_fields.green_one ==
			{out_data.raw[58:56], out_data.raw[52]})
		else $error("H green one misplaced");

	chk_planar_join: assert property (
		out_valid |-> out_data.planar.origin_blue ==
			{out_data.raw[48], out_data.raw[44:43], out_data.raw[41:39]})
		else $error("planar origin blue misjoined");

	cov_diff_block: cover property (out_valid && out_data.mode == MODE_DIFF);
	cov_skid_used: cover property (skid_valid && !ready);
	cov_t_block: cover property (out_valid && out_data.mode == MODE_T);
	cov_punch: cover property (out_valid && out_data.mode == MODE_DIFF
		&& out_data.texels[0].alpha == 8'h00);

endmodule

// [texel_sink_model.sv]
// far-side sampler model that takes decoded blocks at full or slow pace
`timescale 1ns/1ns

module texel_sink_model (
	// clock and reset
	input  wire logic                     core_clk_in,
	input  wire logic                     rst_in,
	// pacing control
	input  wire logic                     slow_in,
	// decoded block stream
	input  wire logic                     out_valid_in,
	input  wire texel_codec_pkg::result_s result_in,
	output logic                          out_ready_out
);
	import texel_codec_pkg::*;

	logic    [1:0] pace;
	result_s       got [$];

	// ready moves only on the falling edge, well away from sampling;
	// held low through reset so that one process alone drives it
	always @(negedge core_clk_in) begin
		if (rst_in) begin
			pace <= 2'h0;
			out_ready_out <= 1'b0;
		end else begin
			pace <= pace + 2'h1;
			// slow pace takes one block in four cycles to back up the buffer
			out_ready_out <= !slow_in || pace == 2'h3;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// a block counts as taken only where valid and ready meet at the edge
	always @(posedge core_clk_in) begin
		if (!rst_in && out_valid_in && out_ready_out) begin
			got.push_back(result_in);
		end
	end
endmodule

// [test_texel_block_decoder.sv]
// self-checking bench for the texel block decoder
`timescale 1ns/1ns

module test_texel_block_decoder;
	import texel_codec_pkg::*;

	localparam int mod_hi [8] = '{8, 17, 29, 42, 60, 80, 106, 183};
	localparam int mod_lo [8] = '{2, 5, 9, 13, 18, 24, 33, 47};

	logic        core_clk_in;
	logic        rst_in;
	logic        in_valid_in;
	logic [63:0] block_in;
	logic        in_ready_out;
	logic        out_valid_out;
	logic        out_ready_in;
	result_s     result_out;
	logic        slow;
	int          num_errors;
	int          compares;
	int          stalls;
	logic [63:0] exp_q [$];

	texel_block_decoder texel_block_decoder_i (
		.core_clk_in   (core_clk_in),
		.rst_in        (rst_in),
		.in_valid_in   (in_valid_in),
		.block_in      (block_in),
		.in_ready_out  (in_ready_out),
		.out_valid_out (out_valid_out),
		.out_ready_in  (out_ready_in),
		.result_out    (result_out)
	);

	texel_sink_model texel_sink_model_i (
		.core_clk_in   (core_clk_in),
		.rst_in        (rst_in),
		.slow_in       (slow),
		.out_valid_in  (out_valid_out),
		.result_in     (result_out),
		.out_ready_out (out_ready_in)
	);

	initial core_clk_in = 1'b0;
	always #5 core_clk_in = ~core_clk_in;

	////////////////////////////////////////////////////////////////////////
	// reference arithmetic, worked out independently of the design
	function automatic int sx(logic [2:0] d);
		return int'(d) - (d[2] ? 8 : 0);
	endfunction

	function automatic int ext5(int v);
		return (v << 3) | (v >> 2);
	endfunction

	function automatic logic [7:0] clamp(int v);
		return (v < 0) ? 8'h00 : (v > 255) ? 8'hFF : 8'(v);
	endfunction

	function automatic mode_e mode_of(logic [63:0] b);
		int r;
		int g;
		int c;
		r = int'(b[63:59]) + sx(b[58:56]);
		g = int'(b[55:51]) + sx(b[50:48]);
		c = int'(b[47:43]) + sx(b[42:40]);
		if (r < 0 || r > 31) return MODE_T;
		if (g < 0 || g > 31) return MODE_H;
		if (c < 0 || c > 31) return MODE_PLANAR;
		return MODE_DIFF;
	endfunction

	function automatic texel_s ref_texel(logic [63:0] b, int i);
		logic [1:0] ix;
		logic       sec;
		int         s;
		int         m;
		texel_s     t;
		ix = {b[16 + i], b[i]};
		sec = b[32] ? (i % 4 >= 2) : (i >= 8);
		s = sec ? int'(b[36:34]) : int'(b[39:37]);
		m = ix[0] ? mod_hi[s] : (b[33] ? mod_lo[s] : 0);
		if (ix[1]) m = -m;
		t.red = clamp(ext5(int'(b[63:59]) + (sec ? sx(b[58:56]) : 0)) + m);
		t.green = clamp(ext5(int'(b[55:51]) + (sec ? sx(b[50:48]) : 0)) + m);
		t.blue = clamp(ext5(int'(b[47:43]) + (sec ? sx(b[42:40]) : 0)) + m);
		t.alpha = 8'hFF;
		if (!b[33] && ix == 2'b10) t = '0;
		return t;
	endfunction

	function automatic logic [63:0] mk(logic [4:0] r, logic [2:0] dr,
		logic [4:0] g, logic [2:0] dg, logic [4:0] c, logic [2:0] dc,
		logic [7:0] mid, logic [31:0] lo);
		return {r, dr, g, dg, c, dc, mid, lo};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// shared reporting and handshake tasks
	task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		if (num_errors == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// the block is held while refused, as the input side requires
	task automatic send(logic [63:0] b);
		int k;
		@(negedge core_clk_in);
		in_valid_in = 1'b1;
		block_in = b;
		for (k = 0; k < 200 && in_ready_out !== 1'b1; k++) begin
			stalls++;
			@(negedge core_clk_in);
		end
		if (in_ready_out !== 1'b1) begin
			num_errors++;
			end_of_test();
		end
		@(posedge core_clk_in);
		exp_q.push_back(b);
	endtask

	task automatic idle();
		@(negedge core_clk_in);
		in_valid_in = 1'b0;
	endtask

	// results must come back in the order sent, none lost
	task automatic collect(int n);
		result_s     r;
		logic [63:0] b;
		texel_s      t;
		int          k;
		repeat (n) begin
			for (k = 0; k < 500 && texel_sink_model_i.got.size() == 0; k++)
				@(negedge core_clk_in);
			if (texel_sink_model_i.got.size() == 0) begin
				num_errors++;
				end_of_test();
			end
			r = texel_sink_model_i.got.pop_front();
			b = exp_q.pop_front();
			check("raw", r.raw, b);
			check("mode", 64'(r.mode), 64'(mode_of(b)));
			check("opacity", 64'(r.opacity_flag), 64'(b[33]));
			for (k = 0; k < 16; k++) begin
				t = (mode_of(b) == MODE_DIFF) ? ref_texel(b, k) : '0;
				check("texel", 64'(r.texels[k]), 64'(t));
			end
			case (mode_of(b))
				MODE_T: check("t_fields", 64'(r.t_fields), 64'({b[60:59],
					b[57:56], b[55:36], b[35:34], b[32]}));
				MODE_H: check("h_fields", 64'(r.h_fields), 64'({b[62:56],
					b[52:51], b[49:35], b[34], b[32], 1'b0}));
				MODE_PLANAR: check("planar", 64'(r.planar), 64'({b[62:56],
					b[54:48], b[44:43], b[41:34], b[32:0]}));
				default: ;
			endcase
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic scen_reset();
		check("ready_rst", 64'(in_ready_out), 64'h0);
		check("valid_rst", 64'(out_valid_out), 64'h0);
	endtask

	// every mode with sums just outside and just inside the range
	task automatic scen_modes();
		logic [63:0] blk [7];
		int          k;
		blk = '{mk(5'h03, 3'h4, 5'h15, 3'h2, 5'h0A, 3'h6, 8'hA7, 32'hC3A596E1),
			mk(5'h1F, 3'h1, 5'h0E, 3'h5, 5'h13, 3'h3, 8'h5B, 32'h1E2D3C4B),
			mk(5'h04, 3'h4, 5'h1F, 3'h1, 5'h09, 3'h2, 8'hD2, 32'h9A8B7C6D),
			mk(5'h1F, 3'h0, 5'h00, 3'h7, 5'h1B, 3'h1, 8'h3C, 32'h5F0AE1B4),
			mk(5'h1C, 3'h3, 5'h10, 3'h0, 5'h00, 3'h7, 8'hE9, 32'h7788A5C3),
			mk(5'h02, 3'h6, 5'h1D, 3'h2, 5'h1D, 3'h3, 8'h66, 32'h0FF0A55A),
			mk(5'h1F, 3'h0, 5'h00, 3'h0, 5'h1C, 3'h3, 8'h95, 32'hB4E17A2C)};
		send(blk[0]);
		idle();
		check("latency", 64'(out_valid_out), 64'h1);
		for (k = 1; k < 7; k++) send(blk[k]);
		idle();
		collect(7);
	endtask

	// all selectors, both opacity settings, both orientations, clamping
	task automatic scen_diff();
		int k;
		stalls = 0;
		for (k = 0; k < 32; k++) send(mk(5'h1F, 3'h4, 5'h00, 3'h3, 5'h10,
			k[0] ? 3'h0 : 3'h5, {3'(k >> 2), 3'(7 - (k >> 2)), k[1], k[0]},
			32'h6C9335A6 ^ (32'(k) * 32'h01030507)));
		idle();
		check("back_to_back", 64'(stalls), 64'h0);
		collect(32);
	endtask

	// slow sampler backs up the two-entry buffer; nothing may be lost
	task automatic scen_stall();
		int k;
		slow = 1'b1;
		stalls = 0;
		for (k = 0; k < 6; k++)
			send(mk(5'(k), 3'h3, 5'h11, 3'h4, 5'h1E, 3'h1, 8'(k * 37),
				32'hF00F5AA5 ^ 32'(k)));
		idle();
		check("refused", 64'(stalls > 0), 64'h1);
		collect(6);
		// a duplicated block would still be taken within two slow turns
		repeat (8) @(negedge core_clk_in);
		check("extra", 64'(texel_sink_model_i.got.size()), 64'h0);
		check("drained", 64'(out_valid_out), 64'h0);
		slow = 1'b0;
	endtask

	// reset with the buffer backed up must empty both slots
	task automatic scen_midreset();
		int k;
		slow = 1'b1;
		for (k = 0; k < 3; k++)
			send(mk(5'h0C, 3'h1, 5'h08, 3'h2, 5'h14, 3'h7, 8'(k * 91),
				32'h3C3C0F0F ^ 32'(k)));
		idle();
		rst_in = 1'b1;
		repeat (2) @(negedge core_clk_in);
		check("ready_mid", 64'(in_ready_out), 64'h0);
		check("valid_mid", 64'(out_valid_out), 64'h0);
		check("result_mid", result_out.raw, 64'h0);
		exp_q.delete();
		texel_sink_model_i.got.delete();
		slow = 1'b0;
		rst_in = 1'b0;
		@(negedge core_clk_in);
		check("ready_up", 64'(in_ready_out), 64'h1);
		send(mk(5'h11, 3'h7, 5'h06, 3'h1, 5'h19, 3'h2, 8'h2E, 32'h5AA5C33C));
		idle();
		collect(1);
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		rst_in = 1'b1;
		in_valid_in = 1'b0;
		block_in = 64'h0;
		slow = 1'b0;
		num_errors = 0;
		compares = 0;
		stalls = 0;
		repeat (5) @(negedge core_clk_in);
		scen_reset();
		rst_in = 1'b0;
		scen_modes();
		scen_diff();
		scen_stall();
		scen_midreset();
		end_of_test();
	end
endmodule
